// File: hdl/scc_clk_regs.vh
// Purpose: constants for the system clock controller
// Assumes: 10 MHz controller clock
// Notes:   definitions only
`ifndef SCC_CLK_REGS_VH
`define SCC_CLK_REGS_VH

`define SCC_CLK_PERIOD_NS  100
`define SCC_XTAL_START_NS  1000000
`define SCC_LF_START_NS    1000000000
`define SCC_XTAL_START_CYC (`SCC_XTAL_START_NS / `SCC_CLK_PERIOD_NS)
`define SCC_LF_START_CYC   (`SCC_LF_START_NS / `SCC_CLK_PERIOD_NS)

`define SCC_GAP_LAST       2'h1
`define SCC_DIV_RST        2'h1
`define SCC_CNT_ZERO       3'h0
`define SCC_LF_RC          2'h0
`define SCC_LF_XTAL        2'h1
`define SCC_LF_EXT         2'h2
`define SCC_CAL_W          24
`define SCC_CAL_ZERO       24'h00_0000
`define SCC_CAL_ONE        24'h00_0001
`define SCC_LEN_ZERO       8'h00
`define SCC_LEN_ONE        8'h01

`endif

// File: hdl/scc_tmr.v
// Purpose: start-up timer, done after LIMIT cycles of run
// Assumes: run low clears the count
// Notes:   done stays high while run stays high
`timescale 1ns/100ps
`default_nettype none
module scc_tmr #(
  parameter WIDTH = 24,
  parameter LIMIT = 10000
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             run,
  output reg              done_ff
);
  reg  [WIDTH-1:0] cnt_ff;
  wire [WIDTH-1:0] lim = LIMIT[WIDTH-1:0];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff  <= {WIDTH{1'b0}};
      done_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= {WIDTH{1'b0}};
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      cnt_ff  <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
      done_ff <= (cnt_ff == lim - {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // scc_tmr
`default_nettype wire

// File: hdl/scc_div.v
// Purpose: system clock halver and cpu clock divider
// Assumes: src_tick pulses once per gated fast source period
// Notes:   a new divisor takes effect only at a count wrap
`timescale 1ns/100ps
`default_nettype none
`include "scc_clk_regs.vh"
module scc_div (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       src_tick,
  input  wire [1:0] div_code,
  output reg        sys_clk_ff,
  output reg        sys_tick_ff,
  output reg        cpu_tick_ff,
  output reg  [1:0] div_cur_ff
);
  reg  [2:0] cnt_ff;

  // last count value before wrap for a divide-by 1, 2, 4 or 8
  function [2:0] last_of;
    input [1:0] code;
    begin
      last_of = (3'h1 << code) - 3'h1;
    end
  endfunction

  wire wrap = (cnt_ff == last_of(div_cur_ff));

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_clk_ff  <= 1'b0;
      sys_tick_ff <= 1'b0;
      cpu_tick_ff <= 1'b0;
      cnt_ff      <= `SCC_CNT_ZERO;
      div_cur_ff  <= `SCC_DIV_RST;
    end else begin
      sys_tick_ff <= src_tick & ~sys_clk_ff;
      cpu_tick_ff <= src_tick & wrap;
      if (src_tick) begin
        sys_clk_ff <= ~sys_clk_ff;
        if (wrap) begin
          // changing only at wrap never yields a short cpu period
          cnt_ff     <= `SCC_CNT_ZERO;
          div_cur_ff <= div_code;
        end else begin
          cnt_ff <= cnt_ff + 3'h1;
        end
      end
    end
  end
endmodule // scc_div
`default_nettype wire

// File: hdl/scc_clk_ctrl.v
// Purpose: fast and low frequency clock control of a system controller
// Assumes: all inputs synchronous to clk; *_tick inputs are one-cycle
// Notes:   oscillator clocks are represented by tick pulses
`timescale 1ns/100ps
`default_nettype none
`include "scc_clk_regs.vh"
// Function
// - system clock is fast source halved
// - software picks crystal or rc fast source
// - crystal may power down while rc selected
// - current fast source is readable
// - cpu clock divides source by 1/2/4/8
// - cpu divider resets to divide by two
// - crystal switched off during sleep
// - fast start-up wakes on rc at once
// - auto mode switches to crystal when stable
// - source indication shows auto switch done
// - manual switch starts a stopped crystal
// - manual switch waits for stable crystal
// - low domain runs from rc after reset
// - external low source selection is sticky
// - three low sources: rc, crystal, clock
// - external low source makes pin input
// - low crystal disables both pin pull-ups
// - low crystal gets about one second start
// - low domain runs, calibrated against system
module scc_clk_ctrl #(
  parameter XTAL_START_CYC = `SCC_XTAL_START_CYC,
  parameter LF_START_CYC   = `SCC_LF_START_CYC
) (
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  xtal_tick,
  input  wire                  rc_tick,
  input  wire                  lf_tick,
  input  wire                  clk_sel_wr,
  input  wire                  clk_sel_xtal,
  input  wire                  clk_sel_pd,
  input  wire                  div_wr,
  input  wire [1:0]            div_code,
  input  wire                  fs_wr,
  input  wire                  fs_en,
  input  wire                  fs_auto,
  input  wire                  sleep_enter,
  input  wire                  wake,
  input  wire                  lf_sel_wr,
  input  wire [1:0]            lf_mode,
  input  wire                  cal_start,
  input  wire [7:0]            cal_len,
  output reg                   xtal_on_ff,
  output reg                   rc_on_ff,
  output reg                   gate_xtal_ff,
  output reg                   gate_rc_ff,
  output reg                   clk_src_xtal_ff,
  output wire                  sys_clk,
  output wire                  cpu_tick,
  output wire [1:0]            cpu_div_cur,
  output reg  [1:0]            lf_mode_ff,
  output reg                   lf_rc_en_ff,
  output reg                   lf_xtal_en_ff,
  output reg                   lf_src_ext_ff,
  output reg                   low_clock_input_pin_in_ff,
  output reg                   low_clock_input_pin_pu_dis_ff,
  output reg                   low_crystal_output_pin_pu_dis_ff,
  output reg                   cal_busy_ff,
  output reg                   cal_done_ff,
  output reg  [`SCC_CAL_W-1:0] cal_result_ff
);
  localparam ST_RUN   = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_GAP   = 2'h2;
  localparam ST_SLEEP = 2'h3;
  localparam CAL_IDLE = 2'h0;
  localparam CAL_SYNC = 2'h1;
  localparam CAL_RUN  = 2'h2;

  reg  [1:0]            st_ff;
  reg  [1:0]            gap_ff;
  reg                   tgt_xtal_ff;
  reg                   xtal_pd_ff;
  reg                   fs_en_ff;
  reg                   fs_auto_ff;
  reg  [1:0]            div_req_ff;
  reg  [1:0]            cal_st_ff;
  reg  [7:0]            cal_left_ff;
  reg  [`SCC_CAL_W-1:0] cal_cnt_ff;
  wire                  xtal_rdy;
  wire                  lf_xtal_rdy;
  wire                  sys_tick;
  wire                  src_tick;

  // only the gated source reaches the dividers
  assign src_tick = (gate_xtal_ff & xtal_tick) | (gate_rc_ff & rc_tick);

  // the start-up count restarts whenever the crystal loses power
  scc_tmr #(.WIDTH(24), .LIMIT(XTAL_START_CYC)) u_xtal_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (xtal_on_ff),
    .done_ff (xtal_rdy)
  );

  scc_tmr #(.WIDTH(32), .LIMIT(LF_START_CYC)) u_lf_tmr (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (lf_xtal_en_ff),
    .done_ff (lf_xtal_rdy)
  );

  scc_div u_div (
    .clk         (clk),
    .reset_n     (reset_n),
    .src_tick    (src_tick),
    .div_code    (div_req_ff),
    .sys_clk_ff  (sys_clk),
    .sys_tick_ff (sys_tick),
    .cpu_tick_ff (cpu_tick),
    .div_cur_ff  (cpu_div_cur)
  );

  // software settings
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_req_ff <= `SCC_DIV_RST;
      fs_en_ff   <= 1'b0;
      fs_auto_ff <= 1'b0;
      xtal_pd_ff <= 1'b0;
    end else begin
      if (div_wr)
        div_req_ff <= div_code;
      if (fs_wr) begin
        fs_en_ff   <= fs_en;
        fs_auto_ff <= fs_auto;
      end
      if (clk_sel_wr)
        xtal_pd_ff <= clk_sel_pd & ~clk_sel_xtal;
    end
  end

  // fast source sequencer; break-before-make with a dead gap
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff           <= ST_WAIT;
      gap_ff          <= 2'h0;
      tgt_xtal_ff     <= 1'b1;
      xtal_on_ff      <= 1'b1;
      rc_on_ff        <= 1'b1;
      gate_xtal_ff    <= 1'b0;
      gate_rc_ff      <= 1'b1;
      clk_src_xtal_ff <= 1'b0;
    end else if (sleep_enter && st_ff != ST_SLEEP) begin
      // sleep overrides a pending switch; the current source becomes the wake target
      st_ff        <= ST_SLEEP;
      xtal_on_ff   <= 1'b0;
      rc_on_ff     <= 1'b0;
      gate_xtal_ff <= 1'b0;
      gate_rc_ff   <= 1'b0;
      tgt_xtal_ff  <= clk_src_xtal_ff;
    end else begin
      case (st_ff)
        ST_SLEEP: begin
          if (wake) begin
            rc_on_ff <= 1'b1;
            if (!tgt_xtal_ff) begin
              gate_rc_ff <= 1'b1;
              st_ff      <= ST_RUN;
            end else if (fs_en_ff) begin
              gate_rc_ff      <= 1'b1;
              clk_src_xtal_ff <= 1'b0;
              xtal_on_ff      <= fs_auto_ff;
              st_ff           <= fs_auto_ff ? ST_WAIT : ST_RUN;
            end else begin
              // no fast start: hold the clock until the crystal settles
              xtal_on_ff <= 1'b1;
              st_ff      <= ST_WAIT;
            end
          end
        end
        ST_RUN: begin
          if (clk_sel_wr) begin
            if (clk_sel_xtal && !clk_src_xtal_ff) begin
              xtal_on_ff  <= 1'b1;
              tgt_xtal_ff <= 1'b1;
              st_ff       <= ST_WAIT;
            end else if (!clk_sel_xtal && clk_src_xtal_ff) begin
              gate_xtal_ff <= 1'b0;
              tgt_xtal_ff  <= 1'b0;
              gap_ff       <= 2'h0;
              st_ff        <= ST_GAP;
            end else if (!clk_sel_xtal) begin
              xtal_on_ff <= ~clk_sel_pd;
            end
          end
        end
        ST_WAIT: begin
          if (clk_sel_wr && !clk_sel_xtal && gate_rc_ff) begin
            xtal_on_ff <= ~clk_sel_pd;
            st_ff      <= ST_RUN;
          end else if (xtal_rdy) begin
            gate_rc_ff  <= 1'b0;
            tgt_xtal_ff <= 1'b1;
            gap_ff      <= 2'h0;
            st_ff       <= ST_GAP;
          end
        end
        // gap: both gates stay closed two cycles before the target opens
        default: begin
          if (gap_ff == `SCC_GAP_LAST) begin
            gate_xtal_ff    <= tgt_xtal_ff;
            gate_rc_ff      <= ~tgt_xtal_ff;
            clk_src_xtal_ff <= tgt_xtal_ff;
            if (!tgt_xtal_ff && xtal_pd_ff)
              xtal_on_ff <= 1'b0;
            st_ff <= ST_RUN;
          end else begin
            gap_ff <= gap_ff + 2'h1;
          end
        end
      endcase
    end
  end

  // low frequency source selection
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lf_mode_ff                       <= `SCC_LF_RC;
      lf_rc_en_ff                      <= 1'b1;
      lf_xtal_en_ff                    <= 1'b0;
      lf_src_ext_ff                    <= 1'b0;
      low_clock_input_pin_in_ff        <= 1'b0;
      low_clock_input_pin_pu_dis_ff    <= 1'b0;
      low_crystal_output_pin_pu_dis_ff <= 1'b0;
    end else begin
      // an rc request after an external choice is ignored
      if (lf_sel_wr && lf_mode_ff == `SCC_LF_RC &&
          (lf_mode == `SCC_LF_XTAL || lf_mode == `SCC_LF_EXT)) begin
        lf_mode_ff                <= lf_mode;
        low_clock_input_pin_in_ff <= 1'b1;
        lf_xtal_en_ff             <= (lf_mode == `SCC_LF_XTAL);
        if (lf_mode == `SCC_LF_XTAL) begin
          low_clock_input_pin_pu_dis_ff    <= 1'b1;
          low_crystal_output_pin_pu_dis_ff <= 1'b1;
        end
      end
      // the rc keeps the domain alive until the crystal has settled
      if (lf_mode_ff == `SCC_LF_EXT ||
          (lf_mode_ff == `SCC_LF_XTAL && lf_xtal_rdy)) begin
        lf_src_ext_ff <= 1'b1;
        lf_rc_en_ff   <= 1'b0;
      end
    end
  end

  // low clock calibration: system ticks over cal_len low periods
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_st_ff     <= CAL_IDLE;
      cal_left_ff   <= `SCC_LEN_ZERO;
      cal_cnt_ff    <= `SCC_CAL_ZERO;
      cal_busy_ff   <= 1'b0;
      cal_done_ff   <= 1'b0;
      cal_result_ff <= `SCC_CAL_ZERO;
    end else begin
      cal_done_ff <= 1'b0;
      case (cal_st_ff)
        CAL_IDLE: begin
          if (cal_start && cal_len != `SCC_LEN_ZERO) begin
            cal_left_ff <= cal_len;
            cal_cnt_ff  <= `SCC_CAL_ZERO;
            cal_busy_ff <= 1'b1;
            cal_st_ff   <= CAL_SYNC;
          end
        end
        CAL_SYNC: begin
          if (lf_tick)
            cal_st_ff <= CAL_RUN;
        end
        default: begin
          if (sys_tick)
            cal_cnt_ff <= cal_cnt_ff + `SCC_CAL_ONE;
          if (lf_tick) begin
            if (cal_left_ff == `SCC_LEN_ONE) begin
              cal_result_ff <= cal_cnt_ff +
                               (sys_tick ? `SCC_CAL_ONE : `SCC_CAL_ZERO);
              cal_done_ff   <= 1'b1;
              cal_busy_ff   <= 1'b0;
              cal_st_ff     <= CAL_IDLE;
            end else begin
              cal_left_ff <= cal_left_ff - `SCC_LEN_ONE;
            end
          end
        end
      endcase
    end
  end
endmodule // scc_clk_ctrl
`default_nettype wire

// File: bench/scc_clk_ctrl_chk.sv
// Purpose: port checker for scc_clk_ctrl
// Assumes: one clock domain, async active-low reset
// Notes:   bound to every scc_clk_ctrl instance
`timescale 1ns/100ps
`default_nettype none
`include "scc_clk_regs.vh"
module scc_clk_ctrl_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sleep_enter,
  input wire logic       xtal_on_ff,
  input wire logic       rc_on_ff,
  input wire logic       gate_xtal_ff,
  input wire logic       gate_rc_ff,
  input wire logic       clk_src_xtal_ff,
  input wire logic       sys_clk,
  input wire logic [1:0] lf_mode_ff,
  input wire logic       lf_rc_en_ff,
  input wire logic       low_clock_input_pin_in_ff,
  input wire logic       low_clock_input_pin_pu_dis_ff,
  input wire logic       low_crystal_output_pin_pu_dis_ff,
  input wire logic       cal_busy_ff,
  input wire logic       cal_done_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_gate_excl;
    !(gate_xtal_ff && gate_rc_ff);
  endproperty
  a_gate_excl: assert property (p_gate_excl)
    else $error("both gates open");
  // three cycles of pipeline slack after the gates close
  property p_sys_hold;
    (!gate_xtal_ff && !gate_rc_ff) [*4] |-> $stable(sys_clk);
  endproperty
  a_sys_hold: assert property (p_sys_hold)
    else $error("system clock moved without a source");
  property p_lf_sticky;
    lf_mode_ff != `SCC_LF_RC |=> $stable(lf_mode_ff);
  endproperty
  a_lf_sticky: assert property (p_lf_sticky)
    else $error("low source left external");
  property p_pin_in;
    lf_mode_ff != `SCC_LF_RC |-> low_clock_input_pin_in_ff;
  endproperty
  a_pin_in: assert property (p_pin_in)
    else $error("low clock pin not input");
  property p_xtal_pu;
    lf_mode_ff == `SCC_LF_XTAL |-> low_clock_input_pin_pu_dis_ff
      && low_crystal_output_pin_pu_dis_ff;
  endproperty
  a_xtal_pu: assert property (p_xtal_pu)
    else $error("pull-ups left on for low crystal");
  property p_lf_rc;
    lf_mode_ff == `SCC_LF_RC |-> lf_rc_en_ff;
  endproperty
  a_lf_rc: assert property (p_lf_rc)
    else $error("low rc off while selected");
  property p_sleep;
    sleep_enter && rc_on_ff |->
      ##1 !(gate_xtal_ff || gate_rc_ff || xtal_on_ff || rc_on_ff);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("fast clocks alive in sleep");
  property p_src_rise;
    $rose(clk_src_xtal_ff) |-> gate_xtal_ff && xtal_on_ff;
  endproperty
  a_src_rise: assert property (p_src_rise)
    else $error("source flag ahead of crystal gate");
  property p_cal;
    cal_done_ff |-> $past(cal_busy_ff);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration done without busy");
endmodule // scc_clk_ctrl_chk
bind scc_clk_ctrl scc_clk_ctrl_chk scc_clk_ctrl_chk_inst (.clk, .reset_n,
  .sleep_enter, .xtal_on_ff, .rc_on_ff, .gate_xtal_ff, .gate_rc_ff,
  .clk_src_xtal_ff, .sys_clk, .lf_mode_ff, .lf_rc_en_ff,
  .low_clock_input_pin_in_ff, .low_clock_input_pin_pu_dis_ff,
  .low_crystal_output_pin_pu_dis_ff, .cal_busy_ff, .cal_done_ff);
`default_nettype wire

// File: bench/scc_clk_ctrl_tb.sv
// Purpose: self-checking bench for scc_clk_ctrl
// Assumes: crystal ticks every cycle while powered, rc every other
// Notes:   low clock every 16 cycles so calibration counts are exact
`timescale 1ns/100ps
`default_nettype none
module scc_clk_ctrl_tb;
  localparam int XS = 20;
  localparam int LS = 50;
  logic clk = 0, reset_n = 0, xtal_tick = 0, rc_tick = 0, lf_tick = 0;
  logic clk_sel_wr = 0, clk_sel_xtal = 0, clk_sel_pd = 0, div_wr = 0;
  logic fs_wr = 0, fs_en = 0, fs_auto = 0, sleep_enter = 0, wake = 0;
  logic lf_sel_wr = 0, cal_start = 0;
  logic [1:0] div_code = 0, lf_mode = 0, cpu_div_cur, lf_mode_ff;
  logic [7:0] cal_len = 0;
  logic xtal_on_ff, rc_on_ff, gate_xtal_ff, gate_rc_ff, clk_src_xtal_ff;
  logic sys_clk, cpu_tick, lf_rc_en_ff, lf_xtal_en_ff, lf_src_ext_ff;
  logic low_clock_input_pin_in_ff, low_clock_input_pin_pu_dis_ff;
  logic low_crystal_output_pin_pu_dis_ff, cal_busy_ff, cal_done_ff;
  logic [23:0] cal_result_ff;
  logic [23:0] exp_q[$];
  int num_errors = 0, samples_checked = 0, lf_cnt = 0, n, k, m;
  logic sys_prev;
  always #50 clk = ~clk;
  // fast oscillators tick only while powered; the low clock ticks every 16 cycles regardless
  always @(posedge clk) begin
    lf_cnt <= (lf_cnt + 1) % 16;
    lf_tick <= (lf_cnt == 15);
    // unknown power before the first reset edge reads as off
    xtal_tick <= (xtal_on_ff === 1'b1);
    rc_tick <= (rc_on_ff === 1'b1) && !rc_tick;
  end
  scc_clk_ctrl #(.XTAL_START_CYC(XS), .LF_START_CYC(LS)) scc_clk_ctrl_inst (
    .clk, .reset_n, .xtal_tick, .rc_tick, .lf_tick, .clk_sel_wr,
    .clk_sel_xtal, .clk_sel_pd, .div_wr, .div_code, .fs_wr, .fs_en,
    .fs_auto, .sleep_enter, .wake, .lf_sel_wr, .lf_mode, .cal_start,
    .cal_len, .xtal_on_ff, .rc_on_ff, .gate_xtal_ff, .gate_rc_ff,
    .clk_src_xtal_ff, .sys_clk, .cpu_tick, .cpu_div_cur, .lf_mode_ff,
    .lf_rc_en_ff, .lf_xtal_en_ff, .lf_src_ext_ff,
    .low_clock_input_pin_in_ff, .low_clock_input_pin_pu_dis_ff,
    .low_crystal_output_pin_pu_dis_ff, .cal_busy_ff, .cal_done_ff,
    .cal_result_ff);
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (exp_q.size() != 0) num_errors++;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int w);
    @(posedge clk);
    case (w)
      0: clk_sel_wr <= 1;
      1: div_wr <= 1;
      2: fs_wr <= 1;
      3: sleep_enter <= 1;
      4: wake <= 1;
      5: lf_sel_wr <= 1;
      default: cal_start <= 1;
    endcase
    @(posedge clk);
    {clk_sel_wr, div_wr, fs_wr, sleep_enter, wake, lf_sel_wr} <= 0;
    cal_start <= 0;
    #1;
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return clk_src_xtal_ff;
      1: return gate_xtal_ff;
      default: return cal_busy_ff;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic v, output int c);
    for (c = 0; c < 400 && sig(w) !== v; c++) cyc(1);
    if (sig(w) !== v) begin
      chk(24'(sig(w)), 24'(v));
      conclude;
    end
  endtask
  // f is system ticks per 16-cycle low period for the active source
  task automatic cal(input int f);
    n = $urandom_range(1, 8);
    exp_q.push_back(24'(n * f));
    cal_len <= 8'(n);
    pulse(6);
    wait_for(2, 0, k);
    cyc(2);
  endtask
  always @(posedge clk) if (cal_done_ff === 1'b1)
    chk(cal_result_ff, exp_q.size() ? exp_q.pop_front() : '1);
  initial begin
    n = $urandom(75);
    cyc(7);
    chk(24'({gate_rc_ff, gate_xtal_ff, clk_src_xtal_ff}), 24'h4);
    chk(24'({cpu_div_cur, lf_mode_ff, lf_rc_en_ff}), 24'h9);
    @(posedge clk) reset_n <= 1;
    wait_for(0, 1, n);
    chk(24'(n >= XS), 24'h1);
    chk(24'({gate_xtal_ff, gate_rc_ff}), 24'h2);
    for (int d = 0; d < 4; d++) begin
      div_code <= 2'(d);
      pulse(1);
      cyc(40);
      chk(24'(cpu_div_cur), 24'(d));
      k = 0;
      m = 0;
      repeat (64) begin
        sys_prev = sys_clk;
        cyc(1);
        k += int'(cpu_tick);
        m += int'(sys_clk !== sys_prev);
      end
      chk(24'(k), 24'(64 >> d));
      // crystal ticks every cycle, so the halved clock flips every cycle
      chk(24'(m), 24'h40);
    end
    cal(8);
    clk_sel_xtal <= 0;
    clk_sel_pd <= 1;
    pulse(0);
    wait_for(0, 0, n);
    cyc(2);
    chk(24'({gate_rc_ff, gate_xtal_ff, xtal_on_ff}), 24'h4);
    cal(4);
    clk_sel_xtal <= 1;
    pulse(0);
    cyc(1);
    chk(24'(xtal_on_ff), 24'h1);
    wait_for(0, 1, n);
    chk(24'(n >= XS - 2), 24'h1);
    for (int a = 1; a >= 0; a--) begin
      fs_en <= 1;
      fs_auto <= 1'(a);
      pulse(2);
      pulse(3);
      cyc(2);
      chk(24'({gate_xtal_ff, gate_rc_ff, xtal_on_ff, rc_on_ff}), 0);
      pulse(4);
      cyc(1);
      chk(24'({gate_rc_ff, clk_src_xtal_ff, xtal_on_ff}), 24'(4 + a));
      if (a == 0) begin
        cyc(30);
        chk(24'(clk_src_xtal_ff), 0);
        pulse(0);
      end
      wait_for(0, 1, n);
    end
    // the fast start setting only changes with a write strobe
    fs_en <= 0;
    pulse(2);
    pulse(3);
    pulse(4);
    cyc(2);
    chk(24'({gate_rc_ff, gate_xtal_ff, clk_src_xtal_ff, xtal_on_ff}),
      3);
    wait_for(1, 1, n);
    lf_mode <= 1;
    pulse(5);
    cyc(1);
    chk(24'({lf_mode_ff, low_clock_input_pin_in_ff, lf_xtal_en_ff,
      low_clock_input_pin_pu_dis_ff, low_crystal_output_pin_pu_dis_ff,
      lf_src_ext_ff}), 24'h3e);
    lf_mode <= 2;
    pulse(5);
    lf_mode <= 0;
    pulse(5);
    cyc(LS + 10);
    chk(24'({lf_mode_ff, lf_src_ext_ff}), 24'h3);
    @(posedge clk) reset_n <= 0;
    cyc(3);
    chk(24'({lf_mode_ff, lf_rc_en_ff, lf_src_ext_ff}), 24'h2);
    @(posedge clk) reset_n <= 1;
    lf_mode <= 3;
    pulse(5);
    cyc(1);
    chk(24'(lf_mode_ff), 0);
    lf_mode <= 2;
    pulse(5);
    cyc(2);
    chk(24'({lf_mode_ff, low_clock_input_pin_in_ff,
      low_clock_input_pin_pu_dis_ff, low_crystal_output_pin_pu_dis_ff,
      lf_src_ext_ff, lf_rc_en_ff}), 24'h52);
    conclude;
  end
endmodule // scc_clk_ctrl_tb
`default_nettype wire
